// ### core/thermal_throttle_params.svh
/*
 Offsets, field positions, reset values and timing counts of the thermal throttle controller.
 Assumes a 250 MHz core clock and a 64-bit register port with byte offsets.
*/
`ifndef THERMAL_THROTTLE_PARAMS_SVH
`define THERMAL_THROTTLE_PARAMS_SVH

`define CLK_MHZ 250
// Register byte offsets
`define OFS_SW_THROTTLE 8'h00
`define OFS_THERM_CFG 8'h08
`define OFS_THERM_STAT 8'h10
// Software throttle control fields
`define SWT_EN_BIT 4
`define SWT_DUTY_HI 3
`define SWT_DUTY_LO 1
// Thermal config fields
`define CFG_CGM_EN_BIT 0
`define CFG_DVFS_EN_BIT 1
`define CFG_IRQ_RISE_BIT 2
`define CFG_IRQ_FALL_BIT 3
`define CFG_TOPMUL_LO 8
`define CFG_VNORM_LO 16
`define CFG_VLOW_LO 24
// Reset values
`define SWT_RST 64'h0000000000000000
`define CFG_RST 64'h0000000000000003
`define TOPMUL_RST 8'h0a
`define VNORM_RST 8'h20
`define VLOW_RST 8'h28
// Fixed hardware trip points, not visible to software
`define TRIP_TEMP 8'h64
`define CATA_TEMP 8'h7d
// Frequency/voltage operating point
`define LOW_RATIO 8'h06
`define DVFS_SUPPORTED 1'b1
// Factory clock gating duty and software default duty, in eighths on; modulation slot in cycles
`define TCC_ON_EIGHTHS 3'h3
`define SW_DUTY_DEFAULT 3'h4
`define MOD_SLOT_CYC 16'h0020
// Times in ns and their cycle counts
`define FREQ_CHANGE_NS 5000
`define FREQ_CHANGE_CYC ((`FREQ_CHANGE_NS * `CLK_MHZ) / 1000)
`define HYST_NS 10000
`define HYST_CYC ((`HYST_NS * `CLK_MHZ + 999) / 1000)
`define VID_STEP_NS 100
`define VID_STEP_CYC ((`VID_STEP_NS * `CLK_MHZ + 999) / 1000)
`define ESCALATE_NS 8000
`define ESCALATE_CYC ((`ESCALATE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### core/thermal_throttle_pkg.sv
/*
 Types of the thermal throttle controller.
 Assumes the params header is included by the design file.
*/
package thermal_throttle_pkg;
	typedef enum logic [5:0] {
		ST_NORMAL = 6'b000001,
		ST_FREQ_DOWN = 6'b000010,
		ST_VOLT_DOWN = 6'b000100,
		ST_LOW = 6'b001000,
		ST_VOLT_UP = 6'b010000,
		ST_FREQ_UP = 6'b100000
	} dvfs_state_e;
	typedef logic [15:0] count_t;
endpackage

// ### core/thermal_throttle_control.sv
/*
 Thermal throttle controller: clock gating monitor, frequency/voltage monitor, software forced
 modulation, hot flag, force input and overheat shutdown.
 Assumes a synchronous register port, a temperature code already synchronous to clock, and
 an asynchronous active-low force input.
*/
// Overview of operation
// - Both methods enabled: frequency/voltage first, clock gating added if still hot.
// - Clock gating enabled and at max temperature: gate core clocks on and off.
// - Trip threshold is a hardware constant; software cannot set or read it.
// - During gating, snooping continues; interrupts latch and serve in clock-on phases.
// - Factory fixed gating duty; period counted in core clocks so shortens with frequency.
// - Gating ends only once cool and the hysteresis timer has expired; clearing the clock gating enable here ends it at once.
// - Frequency/voltage throttling moves from top multiplier to the lowest bus ratio.
// - Frequency changes first, about 5 us, blocking bus and holding interrupts pending.
// - Then voltage code steps one table entry at a time while executing.
// - Exit: restore voltage code first, then normal frequency, after hysteresis.
// - Hot flag asserts at the trip point whatever the enables.
// - Optional interrupt on hot flag assertion or deassertion.
// - Software enable bit starts clock modulation at once, regardless of temperature.
// - Software duty is a three-bit field in eighths, 12.5 to 87.5 percent on.
// - Software modulation while the circuit is engaged uses the factory duty.
// - Force input starts frequency/voltage when both methods are enabled, else clock gating.
// - Force throttles all cores and holds while the input stays asserted.
// - Force input is synchronised into the core clock domain.
// - Hot flag never asserts from the force input alone.
// - Catastrophic temperature shuts down and asserts shutdown, no bus cycles.
`timescale 1ns/1ns
`include "thermal_throttle_params.svh"

module thermal_throttle_control
	import thermal_throttle_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [63:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [63:0] reg_rdata,
	// Temperature and platform pins
	input wire logic [7:0] die_temp,
	input wire logic force_power_cut_n,
	output logic die_hot_flag_n,
	output logic overheat_shutdown_n,
	output logic hot_irq,
	// Core side
	output logic core_clock_enable,
	output logic front_side_bus_block,
	output logic [7:0] core_ratio,
	output logic [7:0] voltage_select_code,
	input wire logic irq_request,
	output logic irq_service
);

	logic [63:0] swt_r, swt_nxt;
	logic [63:0] cfg_r, cfg_nxt;
	logic [63:0] rdata_r, rdata_nxt;
	logic force_meta_r, force_sync_r;
	logic hot_r, hot_irq_r, hot_irq_nxt;
	logic shutdown_r, shutdown_nxt;
	logic gate_active_r, gate_active_nxt;
	dvfs_state_e state_r, state_nxt;
	count_t seq_cnt_r, seq_cnt_nxt;
	count_t hyst_cnt_r, hyst_cnt_nxt;
	count_t esc_cnt_r, esc_cnt_nxt;
	count_t slot_cnt_r, slot_cnt_nxt;
	logic [2:0] eighth_r, eighth_nxt;
	logic [7:0] ratio_r, ratio_nxt;
	logic [7:0] vid_r, vid_nxt;
	logic clk_en_r, clk_en_nxt;
	logic block_r, block_nxt;
	logic irq_pend_r, irq_pend_nxt;
	logic irq_svc_r;

	// Register decode
	wire sel_swt = reg_addr == `OFS_SW_THROTTLE;
	wire sel_cfg = reg_addr == `OFS_THERM_CFG;
	wire sel_stat = reg_addr == `OFS_THERM_STAT;
	wire cgm_en = cfg_r[`CFG_CGM_EN_BIT];
	wire dvfs_en = cfg_r[`CFG_DVFS_EN_BIT];
	wire irq_rise_en = cfg_r[`CFG_IRQ_RISE_BIT];
	wire irq_fall_en = cfg_r[`CFG_IRQ_FALL_BIT];
	wire [7:0] top_mult = cfg_r[`CFG_TOPMUL_LO +: 8];
	wire [7:0] vid_norm = cfg_r[`CFG_VNORM_LO +: 8];
	wire [7:0] vid_low = cfg_r[`CFG_VLOW_LO +: 8];
	wire sw_en = swt_r[`SWT_EN_BIT];
	wire [2:0] sw_duty_raw = swt_r[`SWT_DUTY_HI:`SWT_DUTY_LO];

	// Only writable bits are kept; the rest read back as zero
	wire [63:0] swt_mask = 64'h000000000000001e;
	wire [63:0] cfg_mask = 64'h00000000ffffff0f;

	// Temperature compare against fixed trip points
	wire hot_now = die_temp >= `TRIP_TEMP;
	wire cata_now = die_temp >= `CATA_TEMP;
	wire force_on = !force_sync_r;
	wire trig = hot_now || force_on;

	// Throttle method choice
	wire force_dvfs = force_on && dvfs_en && cgm_en && `DVFS_SUPPORTED;
	wire hot_dvfs = hot_now && dvfs_en && `DVFS_SUPPORTED;
	wire use_dvfs = force_dvfs || hot_dvfs;
	wire hot_gate = hot_now && cgm_en && !hot_dvfs;
	wire force_gate = force_on && cgm_en && !force_dvfs;
	wire hyst_done = hyst_cnt_r >= 16'(`HYST_CYC);
	wire cool_done = !trig && hyst_done;
	// Gating is only added once the lower operating point has had time to work
	wire escalate = (state_r == ST_LOW) && hot_now && cgm_en &&
		(esc_cnt_r >= 16'(`ESCALATE_CYC));

	// Modulation phase and duty
	wire [2:0] sw_duty = (sw_duty_raw == 3'h0) ? `SW_DUTY_DEFAULT : sw_duty_raw;
	wire [2:0] duty = gate_active_r ? `TCC_ON_EIGHTHS : sw_duty;
	wire mod_active = gate_active_r || sw_en;
	wire phase_on = eighth_r < duty;
	wire slot_end = slot_cnt_r == (`MOD_SLOT_CYC - 16'h0001);
	wire freq_block = (state_r == ST_FREQ_DOWN) || (state_r == ST_FREQ_UP);

	// Interrupt service only while clocks run and the bus is free
	// Requests are not counted; several before one service collapse into one
	wire can_service = clk_en_r && !block_r;
	wire svc_now = irq_pend_r && can_service && !irq_svc_r;

	// Read mux
	// Unmapped offsets read as zero; writes to them are dropped
	wire [63:0] stat_word = {32'h00000000, vid_r, ratio_r, 2'h0, state_r,
		3'h0, block_r, clk_en_r, shutdown_r, gate_active_r, hot_r};
	wire [63:0] rd_word = sel_swt ? swt_r :
		sel_cfg ? cfg_r :
		sel_stat ? stat_word : 64'h0000000000000000;

	// Register writes and read data
	always_comb begin
		swt_nxt = swt_r;
		cfg_nxt = cfg_r;
		if (reg_write && sel_swt) begin
			swt_nxt = reg_wdata & swt_mask;
		end
		if (reg_write && sel_cfg) begin
			cfg_nxt = reg_wdata & cfg_mask;
		end
		rdata_nxt = reg_read ? rd_word : 64'h0000000000000000;
	end

	// Hot flag edge interrupt and shutdown latch
	// The edge detector resets to cool, but the rise enable resets clear, so a die already hot at reset gives no interrupt
	always_comb begin
		hot_irq_nxt = (hot_now && !hot_r && irq_rise_en) ||
			(!hot_now && hot_r && irq_fall_en);
		shutdown_nxt = shutdown_r || cata_now;
	end

	// Hysteresis and escalation timers
	// Force counts as a trigger, so hysteresis runs from the later of cool-down and release
	always_comb begin
		hyst_cnt_nxt = hyst_cnt_r;
		if (trig) begin
			hyst_cnt_nxt = 16'h0000;
		end else if (!hyst_done) begin
			hyst_cnt_nxt = hyst_cnt_r + 16'h0001;
		end
		esc_cnt_nxt = 16'h0000;
		if (state_r == ST_LOW && hot_now && esc_cnt_r < 16'(`ESCALATE_CYC)) begin
			esc_cnt_nxt = esc_cnt_r + 16'h0001;
		end else if (state_r == ST_LOW && hot_now) begin
			esc_cnt_nxt = esc_cnt_r;
		end
	end

	// Clock gating activity
	always_comb begin
		gate_active_nxt = gate_active_r;
		if (hot_gate || force_gate || escalate) begin
			gate_active_nxt = 1'b1;
		end else if (cool_done) begin
			gate_active_nxt = 1'b0;
		end
		if (!cgm_en) begin
			gate_active_nxt = 1'b0;
		end
	end

	// Modulation counters run in core clocks, so the period scales with frequency
	// Counters run free, so a new duty may shorten or stretch the current on phase once
	always_comb begin
		slot_cnt_nxt = slot_end ? 16'h0000 : slot_cnt_r + 16'h0001;
		eighth_nxt = slot_end ? eighth_r + 3'h1 : eighth_r;
	end

	// Frequency/voltage sequence
	always_comb begin
		state_nxt = state_r;
		seq_cnt_nxt = seq_cnt_r;
		ratio_nxt = ratio_r;
		vid_nxt = vid_r;
		case (state_r)
			ST_NORMAL: begin
				ratio_nxt = top_mult;
				seq_cnt_nxt = 16'h0000;
				// A reprogrammed normal code is reached one entry per step, never by a jump
				if (vid_r != vid_norm) begin
					seq_cnt_nxt = seq_cnt_r + 16'h0001;
					if (seq_cnt_r >= 16'(`VID_STEP_CYC) - 16'h0001) begin
						vid_nxt = (vid_r < vid_norm) ? vid_r + 8'h01 : vid_r - 8'h01;
						seq_cnt_nxt = 16'h0000;
					end
				end
				if (use_dvfs) begin
					state_nxt = ST_FREQ_DOWN;
					seq_cnt_nxt = 16'h0000;
					ratio_nxt = `LOW_RATIO;
				end
			end
			ST_FREQ_DOWN: begin
				seq_cnt_nxt = seq_cnt_r + 16'h0001;
				if (seq_cnt_r >= 16'(`FREQ_CHANGE_CYC) - 16'h0001) begin
					state_nxt = ST_VOLT_DOWN;
					seq_cnt_nxt = 16'h0000;
				end
			end
			ST_VOLT_DOWN: begin
				seq_cnt_nxt = seq_cnt_r + 16'h0001;
				if (vid_r == vid_low) begin
					state_nxt = ST_LOW;
					seq_cnt_nxt = 16'h0000;
				end else if (seq_cnt_r >= 16'(`VID_STEP_CYC) - 16'h0001) begin
					vid_nxt = (vid_r < vid_low) ? vid_r + 8'h01 : vid_r - 8'h01;
					seq_cnt_nxt = 16'h0000;
				end
			end
			ST_LOW: begin
				if (cool_done) begin
					state_nxt = ST_VOLT_UP;
					seq_cnt_nxt = 16'h0000;
				end
			end
			ST_VOLT_UP: begin
				seq_cnt_nxt = seq_cnt_r + 16'h0001;
				if (use_dvfs) begin
					state_nxt = ST_VOLT_DOWN;
					seq_cnt_nxt = 16'h0000;
				end else if (vid_r == vid_norm) begin
					state_nxt = ST_FREQ_UP;
					ratio_nxt = top_mult;
					seq_cnt_nxt = 16'h0000;
				end else if (seq_cnt_r >= 16'(`VID_STEP_CYC) - 16'h0001) begin
					vid_nxt = (vid_r < vid_norm) ? vid_r + 8'h01 : vid_r - 8'h01;
					seq_cnt_nxt = 16'h0000;
				end
			end
			ST_FREQ_UP: begin
				seq_cnt_nxt = seq_cnt_r + 16'h0001;
				if (seq_cnt_r >= 16'(`FREQ_CHANGE_CYC) - 16'h0001) begin
					state_nxt = ST_NORMAL;
					seq_cnt_nxt = 16'h0000;
				end
			end
			default: begin
				state_nxt = ST_NORMAL;
				seq_cnt_nxt = 16'h0000;
			end
		endcase
		if (!dvfs_en && state_r == ST_NORMAL) begin
			state_nxt = ST_NORMAL;
			ratio_nxt = top_mult;
		end
		// After shutdown the operating point freezes, so the regulator sees no further codes
		if (shutdown_nxt) begin
			state_nxt = state_r;
			seq_cnt_nxt = seq_cnt_r;
			ratio_nxt = ratio_r;
			vid_nxt = vid_r;
		end
	end

	// Core clock, bus block and interrupt holding
	// Clocks stop during a frequency change so the cores never run on a moving clock
	always_comb begin
		clk_en_nxt = !shutdown_nxt && !freq_block && (!mod_active || phase_on);
		block_nxt = freq_block || shutdown_nxt;
		// A request arriving as the pending one is served stays pending
		irq_pend_nxt = irq_request || (irq_pend_r && !svc_now);
	end

	// Force input synchroniser; the first stage feeds only the second
	always_ff @(posedge clock) begin
		if (rst) begin
			force_meta_r <= 1'b1;
			force_sync_r <= 1'b1;
		end else begin
			force_meta_r <= force_power_cut_n;
			force_sync_r <= force_meta_r;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			swt_r <= `SWT_RST;
			cfg_r <= `CFG_RST | {32'h00000000, `VLOW_RST, `VNORM_RST, `TOPMUL_RST, 8'h00};
			rdata_r <= 64'h0000000000000000;
		end else begin
			swt_r <= swt_nxt;
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hot_r <= 1'b0;
			hot_irq_r <= 1'b0;
			shutdown_r <= 1'b0;
			gate_active_r <= 1'b0;
		end else begin
			hot_r <= hot_now;
			hot_irq_r <= hot_irq_nxt;
			shutdown_r <= shutdown_nxt;
			gate_active_r <= gate_active_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hyst_cnt_r <= 16'h0000;
			esc_cnt_r <= 16'h0000;
			slot_cnt_r <= 16'h0000;
			eighth_r <= 3'h0;
		end else begin
			hyst_cnt_r <= hyst_cnt_nxt;
			esc_cnt_r <= esc_cnt_nxt;
			slot_cnt_r <= slot_cnt_nxt;
			eighth_r <= eighth_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= ST_NORMAL;
			seq_cnt_r <= 16'h0000;
			ratio_r <= `TOPMUL_RST;
			vid_r <= `VNORM_RST;
		end else begin
			state_r <= state_nxt;
			seq_cnt_r <= seq_cnt_nxt;
			ratio_r <= ratio_nxt;
			vid_r <= vid_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			clk_en_r <= 1'b1;
			block_r <= 1'b0;
			irq_pend_r <= 1'b0;
			irq_svc_r <= 1'b0;
		end else begin
			clk_en_r <= clk_en_nxt;
			block_r <= block_nxt;
			irq_pend_r <= irq_pend_nxt;
			irq_svc_r <= svc_now;
		end
	end

	// Outputs, all from flip-flops
	assign reg_rdata = rdata_r;
	assign die_hot_flag_n = !hot_r;
	assign overheat_shutdown_n = !shutdown_r;
	assign hot_irq = hot_irq_r;
	assign core_clock_enable = clk_en_r;
	assign front_side_bus_block = block_r;
	assign core_ratio = ratio_r;
	assign voltage_select_code = vid_r;
	assign irq_service = irq_svc_r;

endmodule

// ### tb/thermal_throttle_monitor.sv
/*
 Port checks of the thermal throttle controller.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`include "thermal_throttle_params.svh"

module thermal_throttle_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Watched ports
	input wire logic [7:0] die_temp,
	input wire logic die_hot_flag_n,
	input wire logic overheat_shutdown_n,
	input wire logic front_side_bus_block,
	input wire logic core_clock_enable,
	input wire logic [7:0] voltage_select_code,
	input wire logic irq_service
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	AST_HOT_SET: assert property (die_temp >= `TRIP_TEMP |=> !die_hot_flag_n)
		else $error("hot flag missed a trip temperature");
	AST_HOT_ONLY_TEMP: assert property (die_temp < `TRIP_TEMP |=> die_hot_flag_n)
		else $error("hot flag without a hot die");
	AST_SHUT_SET: assert property (die_temp >= `CATA_TEMP |=> !overheat_shutdown_n)
		else $error("shutdown missed");
	AST_SHUT_STICKY: assert property (!overheat_shutdown_n |=> !overheat_shutdown_n)
		else $error("shutdown released before reset");
	AST_SHUT_QUIET: assert property (!overheat_shutdown_n |=> !irq_service && front_side_bus_block)
		else $error("activity after shutdown");
	AST_SERVE_ON: assert property (irq_service |->
		$past(core_clock_enable) && !$past(front_side_bus_block))
		else $error("interrupt served while clocks stopped or bus blocked");
	AST_SERVE_PULSE: assert property (irq_service |=> !irq_service)
		else $error("service pulse too long");
	AST_VID_STEP: assert property ($changed(voltage_select_code) |->
		(8'(voltage_select_code - $past(voltage_select_code)) == 8'h01 ||
		8'($past(voltage_select_code) - voltage_select_code) == 8'h01))
		else $error("voltage code jumped");
	AST_FREQ_FIRST: assert property (front_side_bus_block |-> $stable(voltage_select_code))
		else $error("voltage moved during frequency change");
endmodule

bind thermal_throttle_control thermal_throttle_monitor mon (.clock(clock), .rst(rst),
	.die_temp(die_temp), .die_hot_flag_n(die_hot_flag_n),
	.overheat_shutdown_n(overheat_shutdown_n), .front_side_bus_block(front_side_bus_block),
	.core_clock_enable(core_clock_enable),
	.voltage_select_code(voltage_select_code), .irq_service(irq_service));

// ### tb/vreg_model.sv
/*
 Voltage regulator model: follows the voltage code one step at a time.
 Assumes the controller clock; a jump of more than one code is flagged.
*/
`timescale 1ns/1ns
`include "thermal_throttle_params.svh"

module vreg_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Code from the controller
	input wire logic [7:0] voltage_select_code,
	output logic step_fault_r
);
	logic [7:0] applied_r;
	logic [7:0] diff;

	assign diff = voltage_select_code - applied_r;

	// Accepts stepwise changes while running
	always_ff @(posedge clock) begin
		if (rst) begin
			applied_r <= `VNORM_RST;
			step_fault_r <= 1'b0;
		end else begin
			applied_r <= voltage_select_code;
			if (diff != 8'h00 && diff != 8'h01 && diff != 8'hff)
				step_fault_r <= 1'b1;
		end
	end
endmodule

// ### tb/thermal_throttle_control_tb.sv
/*
 Self-checking bench of the thermal throttle controller.
 Assumes the package, monitor and regulator model are compiled first.
*/
`timescale 1ns/1ns
`include "thermal_throttle_params.svh"

module thermal_throttle_control_tb;
	logic clock = 0, rst = 1, reg_write = 0, reg_read = 0, rd_d = 0;
	logic force_power_cut_n = 1, irq_request = 0;
	logic [7:0] reg_addr = 0, die_temp = 8'h40, core_ratio, voltage_select_code;
	logic [63:0] reg_wdata = 0, reg_rdata, n_on, irq_cnt = 0, exp_q[$];
	logic die_hot_flag_n, overheat_shutdown_n, hot_irq, core_clock_enable;
	logic front_side_bus_block, irq_service, step_fault;
	int n_fail = 0, checks_done = 0, cyc = 0;

	thermal_throttle_control dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .die_temp(die_temp), .force_power_cut_n(force_power_cut_n),
		.die_hot_flag_n(die_hot_flag_n), .overheat_shutdown_n(overheat_shutdown_n),
		.hot_irq(hot_irq), .core_clock_enable(core_clock_enable),
		.front_side_bus_block(front_side_bus_block), .core_ratio(core_ratio),
		.voltage_select_code(voltage_select_code), .irq_request(irq_request),
		.irq_service(irq_service));
	vreg_model vreg (.clock(clock), .rst(rst), .voltage_select_code(voltage_select_code),
		.step_fault_r(step_fault));

	initial begin
		forever #2 clock = ~clock;
	end

	task summarize;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [63:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [63:0] e);
		@(posedge clock);
		exp_q.push_back(e);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
	endtask

	task settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	// Counts clock-on cycles over one whole modulation period
	task meas;
		n_on = 0;
		repeat (256) begin
			@(posedge clock);
			n_on = n_on + core_clock_enable;
		end
	endtask

	// Read data, hot interrupts and random interrupt requests
	always @(posedge clock) begin
		if (rd_d && exp_q.size() > 0)
			check(reg_rdata, exp_q.pop_front());
		rd_d <= reg_read;
		irq_cnt <= irq_cnt + hot_irq;
		irq_request <= ($urandom_range(15) == 0);
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			summarize;
		end
	end

	initial begin
		logic [2:0] duty;
		void'($urandom(32'he1fedf69));
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		rd(`OFS_THERM_CFG, {32'h00000000, `VLOW_RST, `VNORM_RST, `TOPMUL_RST, 8'h03});
		rd(8'h18, 64'h0);
		duty = 3'($urandom_range(7, 1));
		wr(`OFS_SW_THROTTLE, {59'h0, 1'b1, duty, 1'b0});
		rd(`OFS_SW_THROTTLE, {59'h0, 1'b1, duty, 1'b0});
		wr(`OFS_SW_THROTTLE, '1);
		rd(`OFS_SW_THROTTLE, 64'h1e);
		for (int d = 0; d < 8; d++) begin
			wr(`OFS_SW_THROTTLE, 64'(16 + 2 * d));
			settle(256);
			meas;
			check(n_on, 64'(d == 0 ? 4 : d) * `MOD_SLOT_CYC);
		end
		wr(`OFS_SW_THROTTLE, 64'h0);
		wr(`OFS_THERM_CFG, 64'h28200a0f);
		@(posedge clock);
		die_temp <= `TRIP_TEMP;
		settle(2);
		check(die_hot_flag_n, 1'b0);
		check(core_ratio, `LOW_RATIO);
		check(front_side_bus_block, 1'b1);
		settle(1550);
		check(voltage_select_code, `VLOW_RST);
		check(front_side_bus_block, 1'b0);
		meas;
		check(n_on, 64'd256);
		settle(1900);
		wr(`OFS_SW_THROTTLE, 64'h1e);
		meas;
		check(n_on, `TCC_ON_EIGHTHS * `MOD_SLOT_CYC);
		check(irq_cnt, 64'd1);
		@(posedge clock);
		die_temp <= 8'h40;
		wr(`OFS_SW_THROTTLE, 64'h0);
		settle(2600);
		check(core_ratio, `LOW_RATIO);
		settle(1600);
		check(core_ratio, `TOPMUL_RST);
		check(voltage_select_code, `VNORM_RST);
		check(irq_cnt, 64'd2);
		wr(`OFS_THERM_CFG, 64'h28200a01);
		@(posedge clock);
		// Force pulses are kept far shorter than the platform minimum so the run stays short
		force_power_cut_n <= 1'b0;
		settle(300);
		meas;
		check(n_on, `TCC_ON_EIGHTHS * `MOD_SLOT_CYC);
		check(die_hot_flag_n, 1'b1);
		@(posedge clock);
		force_power_cut_n <= 1'b1;
		settle(2700);
		wr(`OFS_THERM_CFG, 64'h28200a03);
		force_power_cut_n <= 1'b0;
		settle(5);
		check(core_ratio, `LOW_RATIO);
		@(posedge clock);
		force_power_cut_n <= 1'b1;
		settle(1600);
		check(voltage_select_code, `VLOW_RST);
		@(posedge clock);
		die_temp <= `CATA_TEMP;
		settle(2);
		check(overheat_shutdown_n, 1'b0);
		@(posedge clock);
		die_temp <= 8'h40;
		settle(10);
		check(overheat_shutdown_n, 1'b0);
		check(step_fault, 1'b0);
		summarize;
	end
endmodule
